// ==== design/tcos_output_stage.sv ====
// Compare channel output stage with APB registers and complementary pin pairs
//
// How it works
// [R1] Mode 0 keeps the prepare level on a match; mode 1 sets it high on match.
// [R2] Mode 2 drives prepare low on a match; mode 3 toggles it on each match.
// [R3] Modes 6 and 7 are PWM: level from count direction and counter versus compare.
// [R4] Modes 4 and 5 force prepare inactive or active regardless of the comparison.
// [R5] With clear enabled, a high filtered external trigger forces prepare to zero.
// [R6] Once cleared by the trigger, prepare stays low until the next update event.
// [R7] Four channels; first three have complementary pins never both active together in run.
// [R8] Positive and negative pin polarity bits are xor-ed onto the driving signal.
// [R9] Run, offstate off, only positive enabled: positive drives prepare, negative disabled.
// [R10] Run, both enabled: positive is prepare, negative is inverted prepare, both enabled.
// [R11] Run, offstate off, only negative enabled: positive disabled low, negative drives prepare.
// [R12] Run with offstate on: each disabled pin drives its polarity level, stays enabled.
// [R13] Run, offstate on, only negative enabled: positive sits at polarity, negative drives.
// [R14] Idle, idle offstate off, both enables clear: both pins disconnected.
// [R15] Idle otherwise: polarity levels first, idle levels after one dead time if clocked.
// [R16] Prepare and pin selection are registered: pins follow one clock after the cause.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "tcos_regs.svh"

module tcos_output_stage #(
   parameter int NUM_CH  = 4,
   parameter int NUM_CMP = 3,
   parameter int CNT_W   = 16
) (
   // Clock and reset
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_reset,
   // APB slave
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [7:0]           i_paddr,
   input  wire logic [31:0]          i_pwdata,
   output logic                      o_pready,
   output logic [31:0]               o_prdata,
   output logic                      o_pslverr,
   // Counter side
   input  wire logic [CNT_W-1:0]     i_cnt_value,
   input  wire logic                 i_cnt_down,
   input  wire logic                 i_update_evt,
   // External trigger pin, already filtered but asynchronous
   input  wire logic                 i_ext_trig_filtered,
   // Channel pins
   output logic [NUM_CH-1:0]         o_ch_out_pos,
   output logic [NUM_CH-1:0]         o_ch_out_pos_oe,
   output logic [NUM_CMP-1:0]        o_ch_out_neg,
   output logic [NUM_CMP-1:0]        o_ch_out_neg_oe
);

   // Channel fields are four bits each in a half word, so four channels at most
   if (NUM_CH < 1 || NUM_CH > 4 || NUM_CMP < 1 || NUM_CMP > NUM_CH ||
       CNT_W < 1 || CNT_W > 32) begin : gen_param_check
      $error("tcos_output_stage: unsupported parameter values");
   end

   // Configuration registers
   logic                     primary_out_en_reg;
   logic                     ros_reg;
   logic                     ios_reg;
   logic                     dt_run_reg;
   logic [`TCOS_DT_W-1:0]    dead_time_reg;
   logic [2:0]               mode_reg    [NUM_CH];
   logic [NUM_CH-1:0]        clr_en_reg;
   logic [NUM_CH-1:0]        pos_en_reg;
   logic [NUM_CH-1:0]        pos_pol_reg;
   logic [NUM_CH-1:0]        neg_en_reg;
   logic [NUM_CH-1:0]        neg_pol_reg;
   logic [NUM_CH-1:0]        idle_pos_reg;
   logic [NUM_CH-1:0]        idle_neg_reg;
   logic [CNT_W-1:0]         cv_reg      [NUM_CH];

   // Channel state
   logic [NUM_CH-1:0]        prep_reg;
   logic [NUM_CH-1:0]        prep_next;
   logic [NUM_CH-1:0]        hold_reg;
   logic [NUM_CH-1:0]        hold_next;
   logic [`TCOS_DT_W-1:0]    idle_cnt_reg;
   logic                     idle_done;
   logic                     trig_meta_reg;
   logic                     trig_sync_reg;
   tcos_pkg::tcos_pair_t     pair_next   [NUM_CH];

   // Bus state
   logic                     acc;
   logic                     wr_fire;

   // Next prepare level for one channel
   function automatic logic prep_f(input logic [2:0] mode, input logic cur,
                                   input logic match, input logic below,
                                   input logic down);
      logic pwm0;
      pwm0 = down ? (below | match) : below;
      unique case (tcos_pkg::tcos_mode_t'(mode))
         tcos_pkg::TCOS_MODE_KEEP:     prep_f = cur;            // [R1]
         tcos_pkg::TCOS_MODE_SET:      prep_f = cur | match;    // [R1]
         tcos_pkg::TCOS_MODE_CLEAR:    prep_f = cur & ~match;   // [R2]
         tcos_pkg::TCOS_MODE_TOGGLE:   prep_f = cur ^ match;    // [R2]
         tcos_pkg::TCOS_MODE_FORCE_LO: prep_f = 1'b0;           // [R4]
         tcos_pkg::TCOS_MODE_FORCE_HI: prep_f = 1'b1;           // [R4]
         tcos_pkg::TCOS_MODE_PWM0:     prep_f = pwm0;           // [R3]
         tcos_pkg::TCOS_MODE_PWM1:     prep_f = ~pwm0;          // [R3]
      endcase
   endfunction

   // Pin levels and enables of one pair
   function automatic tcos_pkg::tcos_pair_t pair_f(
      input logic prep, input logic pen, input logic nen,
      input logic ppol, input logic npol,
      input logic ipos, input logic ineg);
      tcos_pkg::tcos_pair_t p;
      p = '0;
      if (primary_out_en_reg) begin
         if (pen && nen) begin
            p = '{prep ^ ppol, 1'b1, ~prep ^ npol, 1'b1};          // [R10] [R7]
         end else begin
            if (pen) begin
               p.pos    = prep ^ ppol;                            // [R9] [R8]
               p.pos_oe = 1'b1;
            end else if (ros_reg) begin
               p.pos    = ppol;                                   // [R12] [R13]
               p.pos_oe = 1'b1;
            end
            if (nen) begin
               p.neg    = prep ^ npol;                            // [R11] [R13] [R8]
               p.neg_oe = 1'b1;
            end else if (ros_reg) begin
               p.neg    = npol;                                   // [R12]
               p.neg_oe = 1'b1;
            end
         end
      end else if (ios_reg || pen || nen) begin
         // Idle: polarity levels until the dead time has run out
         p = idle_done ? '{ipos, 1'b1, ineg, 1'b1}
                       : '{ppol, 1'b1, npol, 1'b1};               // [R15]
      end
      // Remaining idle case leaves both pins disconnected          [R14]
      return p;
   endfunction

   // Trigger pin synchroniser
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         trig_meta_reg <= 1'b0;
         trig_sync_reg <= 1'b0;
      end else begin
         trig_meta_reg <= i_ext_trig_filtered;
         trig_sync_reg <= trig_meta_reg;
      end
   end

   // Channel prepare logic and pin selection
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         // Trigger set wins over an update in the same cycle
         hold_next[i] = (clr_en_reg[i] & trig_sync_reg) |
                        (hold_reg[i] & ~i_update_evt);             // [R5] [R6]
         prep_next[i] = prep_f(mode_reg[i], prep_reg[i],
                               i_cnt_value == cv_reg[i],
                               i_cnt_value <  cv_reg[i], i_cnt_down);
         pair_next[i] = pair_f(prep_next[i] & ~hold_next[i],       // [R5]
                               pos_en_reg[i],
                               (i < NUM_CMP) ? neg_en_reg[i] : 1'b0,
                               pos_pol_reg[i], neg_pol_reg[i],
                               idle_pos_reg[i], idle_neg_reg[i]);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         prep_reg <= '0;
         hold_reg <= '0;
      end else begin
         prep_reg <= prep_next;                                   // [R16]
         hold_reg <= hold_next;                                   // [R6]
      end
   end

   // Dead time count after the outputs go idle
   assign idle_done = dt_run_reg && (idle_cnt_reg == dead_time_reg);

   always_ff @(posedge i_sys_clk) begin
      if (i_reset || primary_out_en_reg) begin
         idle_cnt_reg <= '0;
      end else if (dt_run_reg && idle_cnt_reg != dead_time_reg) begin
         idle_cnt_reg <= idle_cnt_reg + `TCOS_DT_W'(1);            // [R15]
      end
   end

   // Registered pins
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_ch_out_pos    <= '0;
         o_ch_out_pos_oe <= '0;
         o_ch_out_neg    <= '0;
         o_ch_out_neg_oe <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            o_ch_out_pos[i]    <= pair_next[i].pos;                // [R16]
            o_ch_out_pos_oe[i] <= pair_next[i].pos_oe;
         end
         // Only the first channels own a negative pin
         for (int i = 0; i < NUM_CMP; i++) begin
            o_ch_out_neg[i]    <= pair_next[i].neg;                // [R7]
            o_ch_out_neg_oe[i] <= pair_next[i].neg_oe;
         end
      end
   end

   // APB: one wait state, so read data is registered like every other output
   assign acc     = i_psel & i_penable;
   assign wr_fire = acc & o_pready & i_pwrite;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `TCOS_OFF_CTRL) || (a == `TCOS_OFF_MODE) ||
                (a == `TCOS_OFF_OUTCFG) || (a == `TCOS_OFF_IDLE) ||
                (a == `TCOS_OFF_STATUS) ||
                (a >= `TCOS_OFF_CV0 && a <= `TCOS_OFF_CV3 && a[1:0] == 2'h0 &&
                 int'(a[3:2]) < NUM_CH);
   endfunction

   function automatic logic [31:0] read_f(input logic [7:0] a);
      logic [31:0] d;
      d = `TCOS_RST_WORD;
      unique case (a)
         `TCOS_OFF_CTRL: begin
            d[`TCOS_CTRL_PRIMARY_OUT_EN]  = primary_out_en_reg;
            d[`TCOS_CTRL_ROS]   = ros_reg;
            d[`TCOS_CTRL_IOS]   = ios_reg;
            d[`TCOS_CTRL_DTRUN] = dt_run_reg;
            d[`TCOS_CTRL_DT_LSB +: `TCOS_DT_W] = dead_time_reg;
         end
         `TCOS_OFF_MODE: begin
            for (int i = 0; i < NUM_CH; i++) begin
               d[i*`TCOS_MODE_STRIDE +: 3] = mode_reg[i];
               d[i*`TCOS_MODE_STRIDE + `TCOS_MODE_CLREN] = clr_en_reg[i];
            end
         end
         `TCOS_OFF_OUTCFG: begin
            for (int i = 0; i < NUM_CH; i++) begin
               d[i*`TCOS_OUT_STRIDE + `TCOS_OUT_PEN]  = pos_en_reg[i];
               d[i*`TCOS_OUT_STRIDE + `TCOS_OUT_PPOL] = pos_pol_reg[i];
               d[i*`TCOS_OUT_STRIDE + `TCOS_OUT_NEN]  = neg_en_reg[i];
               d[i*`TCOS_OUT_STRIDE + `TCOS_OUT_NPOL] = neg_pol_reg[i];
            end
         end
         `TCOS_OFF_IDLE: begin
            d[NUM_CH-1:0] = idle_pos_reg;
            d[`TCOS_IDLE_NEG_LSB +: NUM_CH] = idle_neg_reg;
         end
         `TCOS_OFF_STATUS: begin
            d[NUM_CH-1:0] = prep_reg & ~hold_reg;
            d[`TCOS_STAT_HOLD_LSB +: NUM_CH] = hold_reg;
            d[`TCOS_STAT_TRIG]   = trig_sync_reg;
            d[`TCOS_STAT_IDLEDN] = idle_done;
         end
         default: begin
            if (addr_ok(a)) begin
               d[CNT_W-1:0] = cv_reg[a[3:2]];
            end
         end
      endcase
      return d;
   endfunction

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_pready  <= 1'b0;
         o_prdata  <= `TCOS_RST_WORD;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= acc & ~o_pready;
         if (acc && !o_pready) begin
            o_prdata  <= i_pwrite ? `TCOS_RST_WORD : read_f(i_paddr);
            o_pslverr <= ~addr_ok(i_paddr);
         end else begin
            o_prdata  <= `TCOS_RST_WORD;
            o_pslverr <= 1'b0;
         end
      end
   end

   // Register writes take effect at the edge where pready is seen high
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         primary_out_en_reg      <= 1'b0;
         ros_reg       <= 1'b0;
         ios_reg       <= 1'b0;
         dt_run_reg    <= 1'b0;
         dead_time_reg <= '0;
         clr_en_reg    <= '0;
         pos_en_reg    <= '0;
         pos_pol_reg   <= '0;
         neg_en_reg    <= '0;
         neg_pol_reg   <= '0;
         idle_pos_reg  <= '0;
         idle_neg_reg  <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            mode_reg[i] <= '0;
            cv_reg[i]   <= '0;
         end
      end else if (wr_fire) begin
         unique case (i_paddr)
            `TCOS_OFF_CTRL: begin
               primary_out_en_reg      <= i_pwdata[`TCOS_CTRL_PRIMARY_OUT_EN];
               ros_reg       <= i_pwdata[`TCOS_CTRL_ROS];
               ios_reg       <= i_pwdata[`TCOS_CTRL_IOS];
               dt_run_reg    <= i_pwdata[`TCOS_CTRL_DTRUN];
               dead_time_reg <= i_pwdata[`TCOS_CTRL_DT_LSB +: `TCOS_DT_W];
            end
            `TCOS_OFF_MODE: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  mode_reg[i]   <= i_pwdata[i*`TCOS_MODE_STRIDE +: 3];
                  clr_en_reg[i] <= i_pwdata[i*`TCOS_MODE_STRIDE + `TCOS_MODE_CLREN];
               end
            end
            `TCOS_OFF_OUTCFG: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  pos_en_reg[i]  <= i_pwdata[i*`TCOS_OUT_STRIDE + `TCOS_OUT_PEN];
                  pos_pol_reg[i] <= i_pwdata[i*`TCOS_OUT_STRIDE + `TCOS_OUT_PPOL];
                  // Channels without a negative pin keep its bits at zero
                  neg_en_reg[i]  <= (i < NUM_CMP) &
                                    i_pwdata[i*`TCOS_OUT_STRIDE + `TCOS_OUT_NEN];
                  neg_pol_reg[i] <= (i < NUM_CMP) &
                                    i_pwdata[i*`TCOS_OUT_STRIDE + `TCOS_OUT_NPOL];
               end
            end
            `TCOS_OFF_IDLE: begin
               idle_pos_reg <= i_pwdata[NUM_CH-1:0];
               idle_neg_reg <= i_pwdata[`TCOS_IDLE_NEG_LSB +: NUM_CH];
            end
            default: begin
               if (addr_ok(i_paddr) && i_paddr != `TCOS_OFF_STATUS) begin
                  cv_reg[i_paddr[3:2]] <= i_pwdata[CNT_W-1:0];
               end
            end
         endcase
      end
   end

endmodule

// ==== design/tcos_regs.svh ====
// Register offsets, field positions and widths, and reset values of the output stage
`ifndef TCOS_REGS_SVH
`define TCOS_REGS_SVH

// Byte offsets of the register words
`define TCOS_OFF_CTRL     8'h00
`define TCOS_OFF_MODE     8'h04
`define TCOS_OFF_OUTCFG   8'h08
`define TCOS_OFF_IDLE     8'h0C
`define TCOS_OFF_CV0      8'h10
`define TCOS_OFF_CV1      8'h14
`define TCOS_OFF_CV2      8'h18
`define TCOS_OFF_CV3      8'h1C
`define TCOS_OFF_STATUS   8'h20

// Control word fields
`define TCOS_CTRL_PRIMARY_OUT_EN    0
`define TCOS_CTRL_ROS     1
`define TCOS_CTRL_IOS     2
`define TCOS_CTRL_DTRUN   3
`define TCOS_CTRL_DT_LSB  8
`define TCOS_DT_W         8

// Mode word: four bits per channel, mode in [2:0], clear enable in [3]
`define TCOS_MODE_STRIDE  4
`define TCOS_MODE_CLREN   3

// Output configuration word: four bits per channel
`define TCOS_OUT_STRIDE   4
`define TCOS_OUT_PEN      0
`define TCOS_OUT_PPOL     1
`define TCOS_OUT_NEN      2
`define TCOS_OUT_NPOL     3

// Idle word: positive idle levels from bit 0, negative from bit 4
`define TCOS_IDLE_NEG_LSB 4

// Status word fields
`define TCOS_STAT_HOLD_LSB 4
`define TCOS_STAT_TRIG    8
`define TCOS_STAT_IDLEDN  9

// Reset values
`define TCOS_RST_WORD     32'h0000_0000

`endif

// ==== design/tcos_pkg.sv ====
// Types shared by the timer channel output stage
package tcos_pkg;

   // Compare mode encodings of the prepare signal
   typedef enum logic [2:0] {
      TCOS_MODE_KEEP     = 3'h0,
      TCOS_MODE_SET      = 3'h1,
      TCOS_MODE_CLEAR    = 3'h2,
      TCOS_MODE_TOGGLE   = 3'h3,
      TCOS_MODE_FORCE_LO = 3'h4,
      TCOS_MODE_FORCE_HI = 3'h5,
      TCOS_MODE_PWM0     = 3'h6,
      TCOS_MODE_PWM1     = 3'h7
   } tcos_mode_t;

   // Level and enable of both pins of one pair
   typedef struct packed {
      logic pos;
      logic pos_oe;
      logic neg;
      logic neg_oe;
   } tcos_pair_t;

endpackage

// ==== test/tcos_output_stage_asserts.sv ====
// Port level checks of the output stage, bound to the design
`timescale 1ns/1ps
module tcos_output_stage_asserts #(
   parameter int NUM_CH  = 4,
   parameter int NUM_CMP = 3,
   parameter int CNT_W   = 16
) (
   input wire logic               i_sys_clk,
   input wire logic               i_reset,
   input wire logic               i_psel,
   input wire logic               i_penable,
   input wire logic [7:0]         i_paddr,
   input wire logic               o_pready,
   input wire logic [31:0]        o_prdata,
   input wire logic               o_pslverr,
   input wire logic [NUM_CH-1:0]  o_ch_out_pos,
   input wire logic [NUM_CH-1:0]  o_ch_out_pos_oe,
   input wire logic [NUM_CMP-1:0] o_ch_out_neg,
   input wire logic [NUM_CMP-1:0] o_ch_out_neg_oe
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   chk_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("pready missing after one wait state");
   chk_ready_single: assert property (o_pready |=> !o_pready)
      else $error("pready longer than one cycle");
   chk_ready_cause: assert property (!(i_psel && i_penable) |=> !o_pready)
      else $error("pready without access");
   chk_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("read data outside answer");
   chk_err_ready: assert property (o_pslverr |-> o_pready)
      else $error("slave error without pready");
   chk_unmapped_err: assert property (o_pready && i_paddr > 8'h20 |-> o_pslverr)
      else $error("unmapped access not refused");
   chk_pos_off_low: assert property ((o_ch_out_pos & ~o_ch_out_pos_oe) == '0)
      else $error("disabled positive pin not low");
   chk_neg_off_low: assert property ((o_ch_out_neg & ~o_ch_out_neg_oe) == '0)
      else $error("disabled negative pin not low");
   chk_reset_discon: assert property ($fell(i_reset) |-> !(|{o_ch_out_pos_oe, o_ch_out_neg_oe}))
      else $error("pins driven after reset");
endmodule

bind tcos_output_stage tcos_output_stage_asserts #(
   .NUM_CH(NUM_CH), .NUM_CMP(NUM_CMP), .CNT_W(CNT_W)
) tcos_output_stage_asserts_inst (
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
   .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
   .o_ch_out_pos(o_ch_out_pos), .o_ch_out_pos_oe(o_ch_out_pos_oe),
   .o_ch_out_neg(o_ch_out_neg), .o_ch_out_neg_oe(o_ch_out_neg_oe)
);

// ==== test/tb_tcos_output_stage.sv ====
// Self-checking bench of the output stage against a cycle model
`timescale 1ns/1ps
`include "tcos_regs.svh"
module tb_tcos_output_stage;
   logic        i_sys_clk = 0;
   logic        i_reset = 1;
   logic        i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic [7:0]  i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0;
   logic [15:0] i_cnt_value = 16'h0;
   logic        i_cnt_down = 0, i_update_evt = 0, i_ext_trig_filtered = 0;
   logic        o_pready, o_pslverr;
   logic [31:0] o_prdata;
   logic [3:0]  o_ch_out_pos, o_ch_out_pos_oe, e_pos, e_poe, prep, hold;
   logic [2:0]  o_ch_out_neg, o_ch_out_neg_oe, e_neg, e_noe;
   logic [31:0] ctrl_m = 0, mode_m = 0, out_m = 0, idle_m = 0, rd, w;
   logic [15:0] cv_m [4] = '{default: 16'h0};
   logic        er, s1, s2, done;
   integer      seed = 32'h6038, fails = 0, num_checks = 0, idle_cnt;

   tcos_output_stage tcos_output_stage_inst (
      .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
      .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_cnt_value(i_cnt_value),
      .i_cnt_down(i_cnt_down), .i_update_evt(i_update_evt),
      .i_ext_trig_filtered(i_ext_trig_filtered), .o_ch_out_pos(o_ch_out_pos),
      .o_ch_out_pos_oe(o_ch_out_pos_oe), .o_ch_out_neg(o_ch_out_neg),
      .o_ch_out_neg_oe(o_ch_out_neg_oe));

   always #2.5 i_sys_clk = ~i_sys_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Model sees the inputs as they stood before each edge, like the design
   always @(posedge i_sys_clk) begin : mdl
      logic p, lt, pe, ne, oe;
      if (i_reset) begin
         {prep, hold, s1, s2, e_pos, e_poe, e_neg, e_noe} = '0;
         idle_cnt = 0;
      end else begin
         idle_cnt = ctrl_m[0] ? 0 : idle_cnt + 1;
         done = ctrl_m[3] && idle_cnt > ctrl_m[15:8];
         for (int c = 0; c < 4; c++) begin
            lt = i_cnt_down ? i_cnt_value <= cv_m[c] : i_cnt_value < cv_m[c];
            case (mode_m[4*c+:3])
               3'h1: if (i_cnt_value == cv_m[c]) prep[c] = 1'b1;
               3'h2: if (i_cnt_value == cv_m[c]) prep[c] = 1'b0;
               3'h3: if (i_cnt_value == cv_m[c]) prep[c] = !prep[c];
               3'h4: prep[c] = 1'b0;
               3'h5: prep[c] = 1'b1;
               3'h6: prep[c] = lt;
               3'h7: prep[c] = !lt;
               default: ;
            endcase
            if (i_update_evt) hold[c] = 1'b0;
            if (mode_m[4*c+3] && s2) hold[c] = 1'b1;
            p = prep[c] & !hold[c];
            pe = out_m[4*c];
            ne = out_m[4*c+2];
            if (ctrl_m[0]) begin
               e_poe[c] = pe | ctrl_m[1];
               e_pos[c] = pe ? p ^ out_m[4*c+1] : ctrl_m[1] & out_m[4*c+1];
               if (c < 3) e_noe[c] = ne | ctrl_m[1];
               if (c < 3) e_neg[c] = ne ? (pe ? !p : p) ^ out_m[4*c+3]
                                        : ctrl_m[1] & out_m[4*c+3];
            end else begin
               oe = ctrl_m[2] | pe | ne;
               e_poe[c] = oe;
               e_pos[c] = oe & (done ? idle_m[c] : out_m[4*c+1]);
               if (c < 3) e_noe[c] = oe;
               if (c < 3) e_neg[c] = oe & (done ? idle_m[4+c] : out_m[4*c+3]);
            end
         end
         s2 = s1;
         s1 = i_ext_trig_filtered;
      end
   end

   always @(negedge i_sys_clk)
      if (!i_reset)
         check({o_ch_out_pos, o_ch_out_pos_oe, o_ch_out_neg, o_ch_out_neg_oe},
               {e_pos, e_poe, e_neg, e_noe});

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_sys_clk);
      i_penable <= 1'b1;
      do @(posedge i_sys_clk); while (o_pready !== 1'b1);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      // Masks drop the unused bits, which read back as zero
      if (wr) case (a)
         `TCOS_OFF_CTRL:   ctrl_m <= d & 32'hFF0F;
         `TCOS_OFF_MODE:   mode_m <= d & 32'hFFFF;
         `TCOS_OFF_OUTCFG: out_m <= d & 32'h3FFF;
         `TCOS_OFF_IDLE:   idle_m <= d & 32'hFF;
         8'h10, 8'h14, 8'h18, 8'h1C: cv_m[(a - 8'h10) >> 2] <= d[15:0];
         default: ;
      endcase
   endtask

   function automatic logic [31:0] shadow(input logic [7:0] a);
      case (a)
         `TCOS_OFF_CTRL:   return ctrl_m;
         `TCOS_OFF_MODE:   return mode_m;
         `TCOS_OFF_OUTCFG: return out_m;
         `TCOS_OFF_IDLE:   return idle_m;
         default:          return {16'h0, cv_m[(a - 8'h10) >> 2]};
      endcase
   endfunction

   task automatic run(input int n);
      repeat (n) @(posedge i_sys_clk) begin
         i_cnt_value <= {$random(seed)} % 16;
         i_cnt_down <= $random(seed);
         i_update_evt <= ({$random(seed)} % 16) == 0;
         if ({$random(seed)} % 8 == 0) i_ext_trig_filtered <= !i_ext_trig_filtered;
      end
   endtask

   initial begin
      #100000;
      fails++;
      give_verdict();
   end

   initial begin
      repeat (20) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      for (int a = 0; a <= 8'h24; a += 4) begin
         apb(0, a, 0);
         check(rd, 0);
         check(er, a == 8'h24);
      end
      for (int a = 0; a <= 8'h1C; a += 4) begin
         w = $random(seed) | (a == 0);
         apb(1, a, (a == 8'h0C) ? w & 32'h7F : w);
         apb(0, a, 0);
         check(rd, shadow(a));
      end
      apb(1, 8'h24, 32'hFFFF_FFFF);
      check(er, 1'b1);
      $display("test registers done");
      for (int r = 0; r < 4; r++) begin
         for (int m = 0; m < 8; m++) begin
            apb(1, `TCOS_OFF_OUTCFG, $random(seed));
            apb(1, `TCOS_OFF_CTRL, ($random(seed) & 32'hFF0C) | (r[0] << 1) | 1);
            apb(1, `TCOS_OFF_MODE, ($random(seed) & 32'h8888) | {4{1'b0, m[2:0]}});
            for (int c = 0; c < 4; c++) apb(1, 8'h10 + 4 * c, {$random(seed)} % 16);
            run(40);
         end
      end
      $display("test run modes done");
      for (int k = 0; k < 12; k++) begin
         apb(1, `TCOS_OFF_CTRL, 32'h1);
         apb(1, `TCOS_OFF_OUTCFG, $random(seed));
         apb(1, `TCOS_OFF_IDLE, $random(seed) & 32'h7F);
         apb(1, `TCOS_OFF_CTRL, $random(seed) & 32'h070C);
         run(30);
      end
      $display("test idle done");
      give_verdict();
   end
endmodule
